// file: src/truth_table_reader.sv
// truth table reader for a combinational chip in a 20/24 pin socket
// assumes keys, socket pins and straps are asynchronous to MCLK
//
// Contract
// RL1 - drive every input combination, log outputs
// RL2 - lower pin number takes lower bit
// RL3 - keep only first eight output pins
// RL4 - honour only first eight ground/supply pins
// RL5 - assignment kept until next reset
// RL6 - long start press writes records out
// RL7 - short start press only computes crc32
// RL8 - crc32 names the stored file
// RL9 - default: ten inputs, eight outputs, gnd10, vcc20
// RL10 - select plus jump toggles role group
// RL11 - jump steps role within active group
// RL12 - select moves cursor, start launches readout
// RL13 - outputs sampled as plain logic levels
// RL14 - chip under test must be combinational
// RL15 - readout only with card enabled, present
// RL16 - show configuration five seconds first
// RL17 - one byte per combination, low bits
// RL18 - pin numbers and inputs exported for table
// RL19 - ascending count, sample after settling delay
`timescale 1ns/100ps
`default_nettype none
`include "ttr_cfg.svh"
module truth_table_reader
   import ttr_pkg::*;
#(
   parameter int unsigned SHOW_CYCLES = `TTR_SHOW_S * `TTR_CLK_HZ,
   parameter int unsigned LONG_CYCLES = `TTR_LONG_MS * (`TTR_CLK_HZ / 1000),
   parameter int          FIFO_DEPTH  = `TTR_FIFO_DEPTH
) (
   // clock, reset, enable
   input  wire logic        MCLK,
   input  wire logic        RESETN,
   input  wire logic        CE,
   // configuration straps
   input  wire logic        SD_ENABLE,
   input  wire logic        SD_PRESENT,
   input  wire logic        SOCKET_24,
   // keypad, high while pressed
   input  wire logic        KEY_SELECT,
   input  wire logic        KEY_JUMP,
   input  wire logic        KEY_START,
   // socket pins, index 0 is pin 1
   input  wire logic [23:0] PIN_IN,
   output logic      [23:0] PIN_OUT,
   output logic      [23:0] PIN_OE_N,
   // editing view
   output logic             SHOW_CONFIG,
   output logic             GROUP_SUPPLY,
   output logic      [4:0]  CURSOR,
   output logic      [71:0] ROLE_MAP,
   output logic      [4:0]  IN_COUNT,
   // readout status
   output logic             BUSY,
   output logic             WRITE_MODE,
   output logic             DONE,
   output logic      [31:0] CRC,
   // record stream towards the card writer
   output logic             REC_VALID,
   output logic      [31:0] REC_DATA,
   output logic             REC_LAST,
   input  wire logic        REC_READY
);
   localparam int NP = `TTR_PINS;
   localparam int unsigned SETTLE_CYCLES =
      (`TTR_SETTLE_NS + `TTR_CLK_NS - 1) / `TTR_CLK_NS;

   role_t        role [NP];        // pin roles
   state_t       state;            // sequencer state
   logic [23:0]  pin_meta;         // pin synchroniser, first stage
   logic [23:0]  pin_sync;         // pin synchroniser, second stage
   logic [5:0]   strap_meta;       // straps and keys, first stage
   logic [5:0]   strap_sync;       // straps and keys, second stage
   logic [2:0]   key_prev;         // keys one cycle back
   logic         sel_rise;         // select pressed
   logic         jmp_rise;         // jump pressed
   logic         start_fall;       // start released
   logic         card_ok;          // card support usable
   logic         sock24;           // large socket selected
   logic [31:0]  press_cnt;        // start key hold time
   logic [31:0]  tmr;              // show and settle timer
   logic [23:0]  combo;            // current input combination
   logic [23:0]  last_combo;       // final combination
   logic [7:0]   out_word;         // captured output byte
   logic [7:0]   next_out;         // output byte from the pins
   logic [4:0]   in_rank  [NP];    // input bit of each pin
   logic [4:0]   out_rank [NP];    // output bit of each pin
   logic [4:0]   gnd_rank [NP];    // ground order of each pin
   logic [4:0]   vcc_rank [NP];    // supply order of each pin
   logic [4:0]   n_in;             // number of inputs
   logic [4:0]   npins;            // pins in the socket
   logic         advance;          // record taken, move on
   logic         crc_clear;        // restart crc
   rec_if #(.W(`TTR_REC_W)) push (); // record into the fifo

   // next role within the active group, foreign roles enter it
   function automatic role_t next_role(input role_t r, input logic supply);
      if (supply)
         next_role = (r == ROLE_GND) ? ROLE_VCC : ROLE_GND; // RL11
      else if (r == ROLE_IN)
         next_role = ROLE_OUT; // RL11
      else if (r == ROLE_OUT)
         next_role = ROLE_IGN; // RL11
      else
         next_role = ROLE_IN; // RL11
   endfunction

   // two-stage synchronisers for socket pins, straps and keys
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         pin_meta   <= 24'h000000;
         pin_sync   <= 24'h000000;
         strap_meta <= 6'h00;
         strap_sync <= 6'h00;
      end
      else if (CE)
      begin
         pin_meta   <= PIN_IN;
         pin_sync   <= pin_meta;
         strap_meta <= {SOCKET_24, SD_PRESENT, SD_ENABLE,
                        KEY_START, KEY_JUMP, KEY_SELECT};
         strap_sync <= strap_meta;
      end
   end

   // key history for edge detection
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
         key_prev <= 3'h0;
      else if (CE)
         key_prev <= strap_sync[2:0];
   end

   assign sel_rise   = strap_sync[0] && !key_prev[0];
   assign jmp_rise   = strap_sync[1] && !key_prev[1];
   assign start_fall = !strap_sync[2] && key_prev[2];
   assign card_ok    = strap_sync[3] && strap_sync[4]; // RL15
   assign sock24     = strap_sync[5];
   assign npins      = sock24 ? 5'(`TTR_PINS) : 5'(`TTR_PINS_SMALL);

   // rank of each pin among pins of its role, in pin number order
   always_comb
   begin
      logic [4:0] ci;
      logic [4:0] co;
      logic [4:0] cg;
      logic [4:0] cv;
      ci = 5'h00;
      co = 5'h00;
      cg = 5'h00;
      cv = 5'h00;
      for (int i = 0; i < NP; i++)
      begin
         in_rank[i]  = ci;
         out_rank[i] = co;
         gnd_rank[i] = cg;
         vcc_rank[i] = cv;
         if (i < `TTR_PINS_SMALL || sock24)
         begin
            if (role[i] == ROLE_IN)
               ci = ci + 5'h01; // RL2
            if (role[i] == ROLE_OUT)
               co = co + 5'h01; // RL2
            if (role[i] == ROLE_GND)
               cg = cg + 5'h01; // RL4
            if (role[i] == ROLE_VCC)
               cv = cv + 5'h01; // RL4
         end
      end
      n_in = ci;
   end

   // largest combination for the number of inputs
   assign last_combo = ~(24'hFFFFFF << n_in); // RL1

   // output byte from the sampled pins, extra outputs dropped
   always_comb
   begin
      next_out = 8'h00;
      for (int i = 0; i < NP; i++)
         if ((i < `TTR_PINS_SMALL || sock24) && role[i] == ROLE_OUT
             && out_rank[i] < 5'(`TTR_MAX_OUT))
            next_out[out_rank[i][2:0]] = pin_sync[i]; // RL3 RL13
   end

   // pin roles: default at reset, edited only while idle
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         for (int i = 0; i < NP; i++)
            if (i + 1 == `TTR_DEF_GND_PIN)
               role[i] <= ROLE_GND; // RL9
            else if (i + 1 == `TTR_DEF_VCC_PIN)
               role[i] <= ROLE_VCC; // RL9
            else if (i + 1 >= `TTR_DEF_OUT_FIRST
                     && i + 1 <= `TTR_DEF_OUT_LAST)
               role[i] <= ROLE_OUT; // RL9
            else if (i + 1 <= `TTR_DEF_IN_LAST)
               role[i] <= ROLE_IN; // RL9
            else
               role[i] <= ROLE_IGN;
      end
      else if (CE && state == ST_EDIT && jmp_rise && !strap_sync[0])
         role[CURSOR] <= next_role(role[CURSOR], GROUP_SUPPLY); // RL5 RL11
   end

   // group toggle and cursor movement
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         GROUP_SUPPLY <= 1'b0;
         CURSOR       <= 5'h00;
      end
      else if (CE && state == ST_EDIT)
      begin
         if ((sel_rise || jmp_rise) && strap_sync[0] && strap_sync[1])
            GROUP_SUPPLY <= !GROUP_SUPPLY; // RL10
         else if (sel_rise)
            CURSOR <= (CURSOR + 5'h01 >= npins) ? 5'h00
                                                : CURSOR + 5'h01; // RL12
         else if (CURSOR >= npins)
            CURSOR <= 5'h00; // socket shrank under the cursor
      end
   end

   // start key hold time, saturating
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
         press_cnt <= 32'h00000000;
      else if (CE)
      begin
         if (!strap_sync[2])
            press_cnt <= 32'h00000000;
         else if (press_cnt < LONG_CYCLES)
            press_cnt <= press_cnt + 32'h00000001;
      end
   end

   assign advance   = (state == ST_STORE) && (!WRITE_MODE || push.ready);
   assign crc_clear = (state == ST_SHOW);

   // readout sequencer
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state      <= ST_EDIT;
         WRITE_MODE <= 1'b0;
         tmr        <= 32'h00000000;
         combo      <= 24'h000000;
         out_word   <= 8'h00;
      end
      else if (CE)
      begin
         case (state)
            ST_EDIT:
            begin
               tmr   <= 32'h00000000;
               combo <= 24'h000000;
               if (start_fall && card_ok) // RL12 RL15
               begin
                  WRITE_MODE <= (press_cnt >= LONG_CYCLES); // RL6 RL7
                  state      <= ST_SHOW;
               end
            end
            ST_SHOW:
            begin
               if (tmr >= SHOW_CYCLES - 1) // RL16
               begin
                  tmr   <= 32'h00000000;
                  state <= ST_SETTLE;
               end
               else
                  tmr <= tmr + 32'h00000001;
            end
            ST_SETTLE:
            begin
               if (tmr >= SETTLE_CYCLES - 1) // RL19
               begin
                  out_word <= next_out; // RL13
                  state    <= ST_STORE;
               end
               else
                  tmr <= tmr + 32'h00000001;
            end
            ST_STORE:
            begin
               if (advance)
               begin
                  tmr <= 32'h00000000;
                  if (combo == last_combo)
                     state <= ST_DONE; // RL1
                  else
                  begin
                     combo <= combo + 24'h000001; // RL19
                     state <= ST_SETTLE;
                  end
               end
            end
            ST_DONE:
               state <= ST_EDIT;
            default:
               state <= ST_EDIT;
         endcase
      end
   end

   // socket drive: inputs from the count, first eight supplies
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         PIN_OUT  <= 24'h000000;
         PIN_OE_N <= 24'hFFFFFF;
      end
      else if (CE)
      begin
         for (int i = 0; i < NP; i++)
         begin
            PIN_OUT[i]  <= 1'b0;
            PIN_OE_N[i] <= 1'b1;
            if (state != ST_EDIT && state != ST_DONE
                && (i < `TTR_PINS_SMALL || sock24))
            begin
               if (role[i] == ROLE_IN)
               begin
                  PIN_OUT[i]  <= combo[in_rank[i]]; // RL2
                  PIN_OE_N[i] <= 1'b0;
               end
               else if (role[i] == ROLE_GND
                        && gnd_rank[i] < 5'(`TTR_MAX_SUPPLY))
                  PIN_OE_N[i] <= 1'b0; // RL4
               else if (role[i] == ROLE_VCC
                        && vcc_rank[i] < 5'(`TTR_MAX_SUPPLY))
               begin
                  PIN_OUT[i]  <= 1'b1; // RL4
                  PIN_OE_N[i] <= 1'b0;
               end
            end
         end
      end
   end

   // done pulse at the end of a readout
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
         DONE <= 1'b0;
      else if (CE)
         DONE <= (state == ST_DONE);
   end

   // crc over every output byte, in both modes
   crc32_byte u_crc (
      .clk   (MCLK),
      .rst_n (RESETN),
      .ce    (CE),
      .clear (crc_clear),
      .en    (advance),  // RL7
      .data  (out_word), // RL17
      .crc   (CRC)       // RL8
   );

   // records go out only when a file is written
   assign push.valid = (state == ST_STORE) && WRITE_MODE; // RL6 RL7
   assign push.data  = {combo == last_combo, combo, out_word}; // RL17 RL18

   // record buffer; a stalled drain stalls the scan
   rec_fifo #(
      .WIDTH (`TTR_REC_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (MCLK),
      .rst_n    (RESETN),
      .ce       (CE),
      .wr       (push),
      .rd_valid (REC_VALID),
      .rd_data  ({REC_LAST, REC_DATA}),
      .rd_ready (REC_READY)
   );

   // role map for the display and the table header
   generate
      for (genvar g = 0; g < NP; g++)
      begin : g_map
         assign ROLE_MAP[3*g +: 3] = role[g]; // RL18
      end
   endgenerate

   assign IN_COUNT    = n_in;
   assign SHOW_CONFIG = (state == ST_SHOW); // RL16
   assign BUSY        = (state != ST_EDIT);
endmodule
`default_nettype wire

// file: src/ttr_cfg.svh
// constants of the truth table reader: socket layout, defaults, timing
// assumes a 50 MHz system clock; included by bare name
`ifndef TTR_CFG_SVH
`define TTR_CFG_SVH
// socket size and limits
`define TTR_PINS        24
`define TTR_PINS_SMALL  20
`define TTR_MAX_OUT     8
`define TTR_MAX_SUPPLY  8
// default assignment, pin numbers counted from one
`define TTR_DEF_IN_LAST   11
`define TTR_DEF_GND_PIN   10
`define TTR_DEF_OUT_FIRST 12
`define TTR_DEF_OUT_LAST  19
`define TTR_DEF_VCC_PIN   20
// timing
`define TTR_CLK_HZ      50000000
`define TTR_CLK_NS      20
`define TTR_SHOW_S      5
`define TTR_LONG_MS     1000
`define TTR_SETTLE_NS   1000
// record layout: combination above the output byte, last flag on top
`define TTR_REC_W       33
`define TTR_FIFO_DEPTH  4
`define TTR_CRC_INIT    32'hFFFFFFFF
`define TTR_CRC_POLY    32'hEDB88320
`endif

// file: src/ttr_pkg.sv
// types shared by the truth table reader modules
// assumes ttr_cfg.svh for all numeric constants
package ttr_pkg;
   // role of one socket pin
   typedef enum logic [2:0] {ROLE_IN, ROLE_OUT, ROLE_IGN, ROLE_GND,
                             ROLE_VCC} role_t;
   // readout sequencer states
   typedef enum logic [2:0] {ST_EDIT, ST_SHOW, ST_SETTLE, ST_STORE,
                             ST_DONE} state_t;
endpackage

// file: src/rec_if.sv
// record stream between the sequencer and its fifo
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface rec_if #(parameter int W = 33);
   logic [W-1:0] data;   // record word
   logic         valid;  // word offered
   logic         ready;  // word accepted
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// file: src/rec_fifo.sv
// small first-in first-out buffer for readout records
// assumes one clock; pop side handshake comes from the same domain
`timescale 1ns/100ps
`default_nettype none
module rec_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // fill side
   rec_if.snk                    wr,
   // drain side
   output logic                  rd_valid,
   output logic [WIDTH-1:0]      rd_data,
   input  wire logic             rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];   // storage
   logic [AW:0]      wptr;          // write pointer with wrap bit
   logic [AW:0]      rptr;          // read pointer with wrap bit
   logic             full;          // no room left
   logic             empty;         // nothing held
   logic             do_wr;         // word enters
   logic             do_rd;         // word leaves

   assign empty    = (wptr == rptr);
   assign full     = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
   assign wr.ready = !full;
   assign rd_valid = !empty;
   assign rd_data  = mem[rptr[AW-1:0]];
   assign do_wr    = ce && wr.valid && !full;
   assign do_rd    = ce && rd_ready && !empty;

   // storage write, no reset needed for the data
   always_ff @(posedge clk)
   begin
      if (do_wr)
         mem[wptr[AW-1:0]] <= wr.data;
   end

   // pointer update
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wptr <= '0;
         rptr <= '0;
      end
      else
      begin
         if (do_wr)
            wptr <= wptr + 1'b1;
         if (do_rd)
            rptr <= rptr + 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: src/crc32_byte.sv
// reflected crc32 over a byte stream, one byte per enabled cycle
// assumes the caller clears it before a new stream
`timescale 1ns/100ps
`default_nettype none
`include "ttr_cfg.svh"
module crc32_byte (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // control and data
   input  wire logic        clear,
   input  wire logic        en,
   input  wire logic [7:0]  data,
   // result, final inversion applied
   output logic [31:0]      crc
);
   logic [31:0] acc;        // running remainder
   logic [31:0] next_acc;   // remainder after this byte

   // eight shift steps of the reflected polynomial
   always_comb
   begin
      next_acc = acc ^ {24'h000000, data};
      for (int b = 0; b < 8; b++)
         next_acc = next_acc[0] ? ((next_acc >> 1) ^ `TTR_CRC_POLY)
                                : (next_acc >> 1);
   end

   // remainder register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         acc <= `TTR_CRC_INIT;
      else if (ce && clear)
         acc <= `TTR_CRC_INIT;
      else if (ce && en)
         acc <= next_acc;
   end

   assign crc = ~acc;
endmodule
`default_nettype wire

// file: testbench/ttr_chk.sv
// port checker for the truth table reader: drive, show, records, locks
// assumes CE held high; bound into truth_table_reader below
`timescale 1ns/100ps
`default_nettype none
module ttr_chk #(
   parameter int unsigned SHOW_CYCLES = 20
) (
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RESETN,
   // socket drive
   input  wire logic [23:0] PIN_OUT,
   input  wire logic [23:0] PIN_OE_N,
   // editing and status
   input  wire logic        SHOW_CONFIG,
   input  wire logic [4:0]  CURSOR,
   input  wire logic [71:0] ROLE_MAP,
   input  wire logic        BUSY,
   input  wire logic        WRITE_MODE,
   input  wire logic        DONE,
   // record stream
   input  wire logic        REC_VALID,
   input  wire logic [31:0] REC_DATA,
   input  wire logic        REC_LAST,
   input  wire logic        REC_READY
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   logic [31:0] show_n;  // cycles of the current show period
   logic        scan;    // combinations being driven
   logic        gnd10;   // pin 10 is an honoured ground
   assign scan = BUSY && !SHOW_CONFIG && !DONE;
   // pins 8, 9 not ground keep pin 10 in the first eight
   assign gnd10 = ROLE_MAP[29:27] == 3'h3 && ROLE_MAP[26:24] != 3'h3 &&
                  ROLE_MAP[23:21] != 3'h3;
   // count show cycles, cleared between periods
   always_ff @(posedge MCLK or negedge RESETN)
      if (!RESETN)
         show_n <= '0;
      else
         show_n <= SHOW_CONFIG ? show_n + 32'h1 : '0;
   show_len_a: assert property (
      $fell(SHOW_CONFIG) |-> show_n == SHOW_CYCLES)
      else $error("show period length wrong");
   show_busy_a: assert property (SHOW_CONFIG |-> BUSY)
      else $error("show outside a run");
   idle_float_a: assert property (
      !BUSY && !$past(BUSY) |-> PIN_OE_N == 24'hFFFFFF)
      else $error("pins driven while idle");
   done_pulse_a: assert property (DONE |=> !DONE)
      else $error("done longer than one cycle");
   done_idle_a: assert property (DONE |-> ##[0:1] !BUSY)
      else $error("busy stays after done");
   rec_hold_a: assert property (
      REC_VALID && !REC_READY |=>
      REC_VALID && $stable(REC_DATA) && $stable(REC_LAST))
      else $error("record changed while stalled");
   short_quiet_a: assert property (BUSY && !WRITE_MODE |-> !REC_VALID)
      else $error("record in crc only run");
   gnd_drive_a: assert property (
      scan && gnd10 |-> !PIN_OE_N[9] && !PIN_OUT[9])
      else $error("ground pin not driven low");
   edit_lock_a: assert property (
      BUSY && $past(BUSY) |-> $stable(ROLE_MAP) && $stable(CURSOR))
      else $error("roles changed during a run");
   cover property (DONE && WRITE_MODE);
   cover property (DONE && !WRITE_MODE);
   cover property (REC_VALID && !REC_READY);
endmodule
bind truth_table_reader ttr_chk #(.SHOW_CYCLES(SHOW_CYCLES)) u_chk (
   .MCLK, .RESETN, .PIN_OUT, .PIN_OE_N, .SHOW_CONFIG, .CURSOR, .ROLE_MAP,
   .BUSY, .WRITE_MODE, .DONE, .REC_VALID, .REC_DATA, .REC_LAST, .REC_READY);
`default_nettype wire

// file: testbench/ttr_chip_model.sv
// chip in the socket: combinational, inputs pins 7,8,9,11, outputs 12-19
// assumes the reader drives those inputs; a floating pin flips each cycle
`timescale 1ns/100ps
`default_nettype none
module ttr_chip_model (
   // clock for the floating pattern
   input  wire logic        clk,
   // reader side of the socket
   input  wire logic [23:0] drv,
   input  wire logic [23:0] oe_n,
   output logic      [23:0] pins
);
   logic       flt = 1'h0; // level of an undriven pin
   logic [3:0] c;          // value on the chip inputs
   always @(posedge clk) flt <= ~flt;
   assign c = {drv[10], drv[8], drv[7], drv[6]};
   // outputs follow inputs at once, no state kept
   always_comb
   begin
      for (int i = 0; i < 24; i++)
         pins[i] = oe_n[i] ? flt : drv[i];
      for (int k = 0; k < 8; k++)
         if (oe_n[11 + k])
            pins[11 + k] = k < 4 ? ~c[k] : c[k - 4];
   end
endmodule
`default_nettype wire

// file: testbench/truth_table_reader_bench.sv
// bench: defaults, refused start, role editing, short and long readout
// assumes the chip model in the socket, show 20 and long press 8 cycles
`timescale 1ns/100ps
`default_nettype none
`include "ttr_cfg.svh"
module truth_table_reader_bench
   import ttr_pkg::*;
;
   logic        mclk;       // system clock
   logic        resetn;     // reset, active low
   logic        sd_en;      // card support strap
   logic        sd_in;      // card adapter strap
   logic [2:0]  keys;       // start, jump, select
   logic        rdy;        // record consumer ready
   logic [23:0] pin_in;     // socket levels
   logic [23:0] pin_out;
   logic [23:0] pin_oe_n;
   logic        show, grp, busy, wr_mode, done, rec_valid, rec_last;
   logic [4:0]  cursor, in_count;
   logic [71:0] role_map;
   logic [31:0] crc, rec_data;
   logic [71:0] emap;       // expected role map
   int          fails;
   int          comparisons;
   int          cyc;        // cycles run so far

   truth_table_reader #(
      .SHOW_CYCLES (20),
      .LONG_CYCLES (8),
      .FIFO_DEPTH  (4)
   ) u_dut (
      .MCLK (mclk), .RESETN (resetn), .CE (1'h1),
      .SD_ENABLE (sd_en), .SD_PRESENT (sd_in), .SOCKET_24 (1'h0),
      .KEY_SELECT (keys[0]), .KEY_JUMP (keys[1]), .KEY_START (keys[2]),
      .PIN_IN (pin_in), .PIN_OUT (pin_out), .PIN_OE_N (pin_oe_n),
      .SHOW_CONFIG (show), .GROUP_SUPPLY (grp), .CURSOR (cursor),
      .ROLE_MAP (role_map), .IN_COUNT (in_count), .BUSY (busy),
      .WRITE_MODE (wr_mode), .DONE (done), .CRC (crc),
      .REC_VALID (rec_valid), .REC_DATA (rec_data), .REC_LAST (rec_last),
      .REC_READY (rdy));

   ttr_chip_model u_chip (
      .clk (mclk), .drv (pin_out), .oe_n (pin_oe_n), .pins (pin_in));

   // free running clock
   initial
   begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end

   // cut a hang short
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         results();
      end
   end

   task automatic chk(input string what, input logic [71:0] exp,
                      input logic [71:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // hold keys, release, then idle for gap cycles
   task automatic press(input logic [2:0] k, input int held, input int gap);
      keys = k;
      repeat (held) @(negedge mclk);
      keys = 3'h0;
      repeat (gap) @(negedge mclk);
   endtask

   // select first, jump rises second
   task automatic pair;
      keys = 3'h1;
      repeat (2) @(negedge mclk);
      press(3'h3, 4, 6);
   endtask

   // output byte the model gives for a combination
   function automatic logic [7:0] rbyte(input int n);
      return {n[3:0], ~n[3:0]};
   endfunction

   // reflected crc over the sixteen output bytes
   function automatic logic [31:0] crc_exp;
      logic [31:0] c = `TTR_CRC_INIT;
      for (int n = 0; n < 16; n++)
      begin
         c = c ^ {24'h0, rbyte(n)};
         for (int j = 0; j < 8; j++)
            c = c[0] ? (c >> 1) ^ `TTR_CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction

   // run to done and drained fifo, checking each record taken
   task automatic scan(input logic wr, output int sn, output int n,
                       output int nv);
      logic dn;
      dn = 1'h0;
      sn = 0;
      n = 0;
      nv = 0;
      for (int t = 0; t < 3000 && !(dn && rec_valid !== 1'h1); t++)
      begin
         @(negedge mclk);
         sn += int'(show);
         nv += int'(rec_valid);
         dn |= done;
         rdy = wr && t > 600;
         if (rec_valid && rdy)
         begin
            chk("record", {n == 15, n[23:0], rbyte(n)},
                {rec_last, rec_data});
            n++;
         end
      end
      chk("done", 1, dn);
   endtask

   task automatic check_defaults;
      emap = '0;
      for (int i = 11; i < 19; i++)
         emap[i*3 +: 3] = ROLE_OUT;
      for (int i = 20; i < 24; i++)
         emap[i*3 +: 3] = ROLE_IGN;
      emap[29:27] = ROLE_GND;
      emap[59:57] = ROLE_VCC;
      chk("roles", emap, role_map);
      chk("inputs", 10, in_count);
      chk("cursor", 0, cursor);
      chk("pin enables", 24'hFFFFFF, pin_oe_n);
   endtask

   // start without card support or without the adapter
   task automatic refused_start;
      for (int m = 1; m < 3; m++)
      begin
         {sd_en, sd_in} = m[1:0];
         press(3'h4, 3, 10);
         chk("busy", 0, busy);
      end
      sd_en = 1'h1;
      sd_in = 1'h1;
   endtask

   // pins 1-6 ignored, supply group walk on pin 8, cursor wrap
   task automatic edit_roles;
      for (int i = 0; i < 6; i++)
      begin
         press(3'h2, 4, 6);
         press(3'h2, 4, 6);
         press(3'h1, 4, 6);
         emap[i*3 +: 3] = ROLE_IGN;
      end
      chk("roles", emap, role_map);
      chk("cursor", 6, cursor);
      chk("inputs", 4, in_count);
      pair();
      chk("group", 1, grp);
      chk("cursor", 7, cursor);
      press(3'h2, 4, 6);
      chk("pin 8 role", ROLE_GND, role_map[23:21]);
      press(3'h2, 4, 6);
      chk("pin 8 role", ROLE_VCC, role_map[23:21]);
      press(3'h2, 4, 6);
      chk("pin 8 role", ROLE_GND, role_map[23:21]);
      pair();
      chk("group", 0, grp);
      repeat (19) press(3'h1, 4, 6);
      chk("cursor", 7, cursor);
      press(3'h2, 4, 6);
      chk("roles", emap, role_map);
   endtask

   task automatic short_run;
      int sn, n, nv;
      press(3'h4, 3, 0);
      scan(1'h0, sn, n, nv);
      chk("show cycles", 20, sn);
      chk("records", 0, nv);
      chk("write mode", 0, wr_mode);
      chk("crc", crc_exp(), crc);
   endtask

   // long press, consumer stalls first then drains
   task automatic long_run;
      int sn, n, nv;
      press(3'h4, 12, 0);
      scan(1'h1, sn, n, nv);
      chk("records", 16, n);
      chk("write mode", 1, wr_mode);
      chk("crc", crc_exp(), crc);
      chk("roles kept", emap, role_map);
   endtask

   task automatic results;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // main sequence
   initial
   begin
      resetn = 1'h0;
      sd_en = 1'h1;
      sd_in = 1'h1;
      keys = 3'h0;
      rdy = 1'h0;
      repeat (12) @(negedge mclk);
      resetn = 1'h1;
      repeat (3) @(negedge mclk);
      check_defaults();
      refused_start();
      edit_roles();
      short_run();
      long_run();
      results();
   end
endmodule
`default_nettype wire
